// ---- include/gpc_pkg.sv ----
/*
 * constants, state layout and register map of the output-pin configuration
 * block reached over the serial control port.
 * assumes the serial port pins are synchronous to CLK_I and that the serial
 * clock runs at most a quarter of the crystal clock.
 */
package gpc_pkg;

    // ==================================================================
    // serial address space
    localparam logic [5:0] ADDR_OUT1_CFG = 6'h01;
    localparam logic [5:0] ADDR_OUT0_CFG = 6'h02;
    localparam logic [5:0] ADDR_SPECIAL_BASE = 6'h30;
    localparam logic [5:0] ADDR_MULTI_BASE = 6'h3e;
    localparam int HDR_READ_BIT = 7;
    localparam int HDR_BURST_BIT = 6;
    localparam logic [7:0] STATUS_BYTE = 8'h00;

    // ==================================================================
    // register fields and reset values
    localparam int DRIVE_BIT = 7;
    localparam int TEMP_BIT = 7;
    localparam int INV_BIT = 6;
    localparam logic [7:0] RST_OUT1_CFG = 8'h2e;
    localparam logic [7:0] RST_OUT0_CFG = 8'h3f;
    localparam logic [5:0] SEL_TRISTATE = 6'h2e;
    localparam logic [5:0] SEL_XOSC_DIV = 6'h3f;

    // ==================================================================
    // crystal divider
    localparam int XOSC_DIV_RATIO = 192;
    localparam logic [7:0] DIV_HALF_LAST = 8'(XOSC_DIV_RATIO / 2 - 1);

    // ==================================================================
    // state
    typedef enum logic {
        PH_HEADER,
        PH_DATA
    } gpc_phase_t;

    typedef struct packed {
        logic csn_q;
        logic sclk_q;
        logic [2:0] bit_cnt;
        logic [6:0] shift;
        gpc_phase_t phase;
        logic rd;
        logic burst;
        logic [5:0] addr;
        logic [7:0] tx;
        logic tx_hold;
        logic miso;
        logic so_oe;
        logic [7:0] cfg1;
        logic [7:0] cfg0;
        logic [7:0] div_cnt;
        logic div_clk;
        logic pin1;
        logic pin1_oe;
        logic pin0;
        logic pin0_oe;
        logic strobe;
        logic [5:0] strobe_addr;
    } gpc_state_t;

    localparam gpc_state_t ST_RESET = '{
        csn_q: 1'b1,
        phase: PH_HEADER,
        cfg1: RST_OUT1_CFG,
        cfg0: RST_OUT0_CFG,
        default: '0
    };

endpackage

// ---- hdl/gpc_pin_config.sv ----
/*
 * serial-port register slice holding the two output-pin configuration
 * registers, the pin source multiplexers and the crystal divider.
 * assumes CSN_I, SCLK_I and SI_I are synchronous to CLK_I, the serial clock
 * is at most a quarter of CLK_I, and CLK_I is the crystal clock.
 */
module gpc_pin_config
    import gpc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic CSN_I,
    input wire logic SCLK_I,
    input wire logic SI_I,
    input wire logic [63:0] SRC_I,
    output logic SO_O,
    output logic SO_OE_O,
    output logic PIN1_O,
    output logic PIN1_OE_O,
    output logic PIN0_O,
    output logic PIN0_OE_O,
    output logic DRIVE_HIGH_O,
    output logic TEMP_SENSOR_EN_O,
    output logic STROBE_O,
    output logic [5:0] STROBE_ADDR_O
);

    gpc_state_t st_ff;
    gpc_state_t nxt_st;

    // ==================================================================
    // decode helpers
    function automatic logic [7:0] reg_read(input logic [5:0] a,
                                            input logic [7:0] c1,
                                            input logic [7:0] c0);
        logic [7:0] r;
        r = 8'h00;
        if (a == ADDR_OUT1_CFG) begin
            r = c1;
        end else if (a == ADDR_OUT0_CFG) begin
            r = c0;
        end
        return r;
    endfunction

    function automatic logic pin_src(input logic [5:0] sel,
                                     input logic [63:0] src,
                                     input logic div);
        return (sel == SEL_XOSC_DIV) ? div : src[sel];
    endfunction

    logic sclk_rise;
    logic sclk_fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic cfg_wr;

    assign sclk_rise = !CSN_I && SCLK_I && !st_ff.sclk_q;
    assign sclk_fall = !CSN_I && !SCLK_I && st_ff.sclk_q;
    assign byte_done = sclk_rise && (st_ff.bit_cnt == 3'h7);
    assign rx_byte = {st_ff.shift, SI_I};
    // data writes at or above the special region are dropped and change no register
    assign cfg_wr = byte_done && (st_ff.phase == PH_DATA) && !st_ff.rd &&
                    (st_ff.addr < ADDR_SPECIAL_BASE);

    // ==================================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.strobe = 1'b0;
        nxt_st.csn_q = CSN_I;
        nxt_st.sclk_q = SCLK_I;
        nxt_st.so_oe = !CSN_I;

        if (st_ff.div_cnt == DIV_HALF_LAST) begin
            nxt_st.div_cnt = 8'h00;
            nxt_st.div_clk = !st_ff.div_clk;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
        end

        if (CSN_I) begin
            nxt_st.bit_cnt = 3'h0;
            nxt_st.phase = PH_HEADER;
            nxt_st.tx = STATUS_BYTE;
            nxt_st.tx_hold = 1'b0;
        end else if (sclk_rise) begin
            nxt_st.shift = rx_byte[6:0];
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
            if (byte_done) begin
                // new byte is already on SO; the next falling edge must not
                // shift it away
                nxt_st.tx_hold = 1'b1;
                if (st_ff.phase == PH_HEADER) begin
                    nxt_st.rd = rx_byte[HDR_READ_BIT];
                    nxt_st.burst = rx_byte[HDR_BURST_BIT];
                    nxt_st.addr = rx_byte[5:0];
                    if (rx_byte[5:0] >= ADDR_SPECIAL_BASE &&
                        rx_byte[5:0] < ADDR_MULTI_BASE &&
                        !rx_byte[HDR_BURST_BIT]) begin
                        nxt_st.strobe = 1'b1;
                        nxt_st.strobe_addr = rx_byte[5:0];
                        nxt_st.tx = STATUS_BYTE;
                    end else begin
                        nxt_st.phase = PH_DATA;
                        nxt_st.tx = reg_read(rx_byte[5:0], st_ff.cfg1,
                                             st_ff.cfg0);
                    end
                end else begin
                    if (cfg_wr && st_ff.addr == ADDR_OUT1_CFG) begin
                        nxt_st.cfg1 = rx_byte;
                    end
                    if (cfg_wr && st_ff.addr == ADDR_OUT0_CFG) begin
                        nxt_st.cfg0 = rx_byte;
                    end
                    if (st_ff.burst && st_ff.addr < ADDR_SPECIAL_BASE) begin
                        nxt_st.addr = st_ff.addr + 6'h01;
                        nxt_st.tx = reg_read(nxt_st.addr, nxt_st.cfg1,
                                             nxt_st.cfg0);
                    end else if (st_ff.burst) begin
                        nxt_st.tx = STATUS_BYTE;
                    end else begin
                        nxt_st.phase = PH_HEADER;
                        nxt_st.tx = STATUS_BYTE;
                    end
                end
            end
        end else if (sclk_fall) begin
            if (st_ff.tx_hold) begin
                nxt_st.tx_hold = 1'b0;
            end else begin
                nxt_st.tx = {st_ff.tx[6:0], 1'b0};
            end
        end
        nxt_st.miso = nxt_st.tx[7];

        // inversion sits after the multiplexer, so it also flips the divider;
        // a three-stated pin holds 0 so no stale source shows on its value
        nxt_st.pin1_oe = st_ff.cfg1[5:0] != SEL_TRISTATE;
        nxt_st.pin1 = nxt_st.pin1_oe &&
                      (pin_src(st_ff.cfg1[5:0], SRC_I, st_ff.div_clk) ^
                       st_ff.cfg1[INV_BIT]);
        nxt_st.pin0_oe = st_ff.cfg0[5:0] != SEL_TRISTATE;
        nxt_st.pin0 = nxt_st.pin0_oe &&
                      (pin_src(st_ff.cfg0[5:0], SRC_I, st_ff.div_clk) ^
                       st_ff.cfg0[INV_BIT]);
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==================================================================
    // outputs
    assign SO_O = st_ff.miso;
    assign SO_OE_O = st_ff.so_oe;
    assign PIN1_O = st_ff.pin1;
    assign PIN1_OE_O = st_ff.pin1_oe;
    assign PIN0_O = st_ff.pin0;
    assign PIN0_OE_O = st_ff.pin0_oe;
    assign DRIVE_HIGH_O = st_ff.cfg1[DRIVE_BIT];
    assign TEMP_SENSOR_EN_O = st_ff.cfg0[TEMP_BIT];
    assign STROBE_O = st_ff.strobe;
    assign STROBE_ADDR_O = st_ff.strobe_addr;

    // ==================================================================
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    sequence s_wr1;
        cfg_wr && st_ff.addr == ADDR_OUT1_CFG;
    endsequence

    sequence s_wr0;
        cfg_wr && st_ff.addr == ADDR_OUT0_CFG;
    endsequence

    a_cfg1_write: assert property (s_wr1 |=> st_ff.cfg1 == $past(rx_byte))
        else $error("pin-1 register did not take written byte");
    a_burst_step: assert property (byte_done && st_ff.phase == PH_DATA &&
        st_ff.burst && st_ff.addr < ADDR_SPECIAL_BASE |=>
        st_ff.addr == $past(st_ff.addr) + 6'h01)
        else $error("burst address did not advance");
    a_strobe_pulse: assert property (byte_done && st_ff.phase == PH_HEADER &&
        rx_byte[5:0] >= ADDR_SPECIAL_BASE && rx_byte[5:0] < ADDR_MULTI_BASE &&
        !rx_byte[HDR_BURST_BIT] |=> STROBE_O ##1 !STROBE_O)
        else $error("strobe header gave no single pulse");
    a_special_nowr: assert property (byte_done && st_ff.phase == PH_DATA &&
        st_ff.addr >= ADDR_SPECIAL_BASE |=>
        $stable(st_ff.cfg1) && $stable(st_ff.cfg0))
        else $error("special region write changed a register");
    a_drive_sel: assert property (s_wr1 |=>
        DRIVE_HIGH_O == $past(rx_byte[DRIVE_BIT]))
        else $error("drive strength not taken from bit 7");
    a_pin1_inv: assert property (PIN1_OE_O |->
        PIN1_O == ($past(pin_src(st_ff.cfg1[5:0], SRC_I, st_ff.div_clk)) ^
                   $past(st_ff.cfg1[INV_BIT])))
        else $error("pin 1 polarity wrong");
    a_pin1_tri: assert property (st_ff.cfg1[5:0] == SEL_TRISTATE |=>
        !PIN1_OE_O)
        else $error("pin 1 driven while three-state selected");
    a_pin0_inv: assert property (PIN0_OE_O |->
        PIN0_O == ($past(pin_src(st_ff.cfg0[5:0], SRC_I, st_ff.div_clk)) ^
                   $past(st_ff.cfg0[INV_BIT])))
        else $error("pin 0 polarity wrong");
    a_div_period: assert property ($changed(st_ff.div_clk) |->
        ##96 $changed(st_ff.div_clk))
        else $error("divided clock half period is not 96");
    a_div_steady: assert property ($changed(st_ff.div_clk) |=>
        (!$changed(st_ff.div_clk)) [*8])
        else $error("divided clock toggled early");
    a_temp_en: assert property (s_wr0 |=>
        TEMP_SENSOR_EN_O == $past(rx_byte[TEMP_BIT]))
        else $error("temperature enable not taken from bit 7");
    a_pin0_xosc: assert property (st_ff.cfg0 == RST_OUT0_CFG &&
        $stable(st_ff.cfg0) && PIN0_OE_O |->
        PIN0_O == $past(st_ff.div_clk))
        else $error("pin 0 does not follow divided clock");

endmodule

// ---- sim/gpc_host_model.sv ----
/*
 * host side of the serial control port: frames and byte transfers.
 * assumes the block samples the serial pins on the same clock.
 */
module gpc_host_model (
    input wire logic clk_i,
    input wire logic so_i,
    output logic csn_n_o,
    output logic sclk_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // transfers
    initial begin
        csn_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic sel(input logic on);
        tick(1);
        csn_n_o = !on;
        tick(2);
    endtask
    // each level is held 3 clocks, the block needs at least 2
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            tick(3);
            rx[i] = so_i;
            sclk_o = 1'b1;
            tick(3);
            sclk_o = 1'b0;
        end
        si_o = !tx[0];
    endtask
endmodule

// ---- sim/tb_gpc_pin_config.sv ----
/*
 * self-checking bench of the output-pin configuration registers.
 * assumes the host model drives the serial pins and gpc_pkg is compiled.
 */
`define CHK(e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t exp %h got %h", $time, e, a); end end
module tb_gpc_pin_config import gpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n, csn_n, sclk, si, so, so_oe;
    logic p1, p1oe, p0, p0oe, drive, temp, strobe;
    logic [5:0] strobe_addr, s, s2;
    logic [63:0] src;
    logic [31:0] seed = 32'h2c0e;
    logic [7:0] act, r, cfg1, exp_v;
    logic [7:0] q[$];
    int n_mismatch = 0, n_tests = 0, n_strobe = 0, c;
    event got;
    wire logic [7:0] pinb = {drive, temp, p1oe, p1, p0oe, p0, 2'b00};
    always #12.5 clk = ~clk;
    gpc_host_model host (.clk_i(clk), .so_i(so), .csn_n_o(csn_n),
        .sclk_o(sclk), .si_o(si));
    gpc_pin_config uut (.CLK_I(clk), .ARST_N_I(arst_n), .CSN_I(csn_n),
        .SCLK_I(sclk), .SI_I(si), .SRC_I(src), .SO_O(so), .SO_OE_O(so_oe),
        .PIN1_O(p1), .PIN1_OE_O(p1oe), .PIN0_O(p0), .PIN0_OE_O(p0oe),
        .DRIVE_HIGH_O(drive), .TEMP_SENSOR_EN_O(temp), .STROBE_O(strobe),
        .STROBE_ADDR_O(strobe_addr));
    // ==========================================================
    // helpers
    function automatic logic [31:0] nxt(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // the tick keeps two notes from landing in one time step
    task automatic note(input logic [7:0] e, input logic [7:0] a);
        host.tick(1);
        q.push_back(e);
        act = a;
        -> got;
    endtask
    task automatic wr(input logic [7:0] h, input int n, input [15:0] d);
        host.sel(1'b1);
        host.xfer(h, r);
        for (int i = 0; i < n; i++) host.xfer(d[15-8*i -: 8], r);
        host.sel(1'b0);
    endtask
    task automatic rd(input logic [7:0] h, input int n, input [15:0] e);
        host.sel(1'b1);
        host.xfer(h, r);
        note(8'h01, {7'h00, so_oe});
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h00, r);
            note(e[15-8*i -: 8], r);
        end
        host.sel(1'b0);
    endtask
    always @(got) begin
        exp_v = q.pop_front();
        `CHK(exp_v, act)
    end
    always @(posedge clk) if (strobe === 1'b1) n_strobe++;
    initial begin
        #500000;
        n_mismatch++;
        results();
    end
    // ==========================================================
    // scenarios
    initial begin
        arst_n = 1'b0;
        src = {nxt(seed), seed};
        repeat (16) @(posedge clk);
        #2 arst_n = 1'b1;
        host.tick(1);
        note(8'h08, pinb & 8'hf8);
        rd(8'hc1, 2, {RST_OUT1_CFG, RST_OUT0_CFG});
        act[2] = p0;
        for (c = 0; c < 400 && p0 === act[2]; c++) host.tick(1);
        act[2] = p0;
        for (c = 0; c < 400 && p0 === act[2]; c++) host.tick(1);
        note(8'd96, 8'(c));
        for (int k = 0; k < 6; k++) begin
            seed = nxt(seed);
            src = {seed, nxt(seed)};
            seed = nxt(seed);
            s = seed[5:0] % 6'h2e;
            s2 = seed[13:8] % 6'h2e;
            cfg1 = {seed[7:6], s};
            wr(8'h41, 2, {cfg1, 1'b0, seed[14], s2});
            note({seed[7], 2'b01, src[s] ^ seed[6], 1'b1,
                src[s2] ^ seed[14], 2'b00}, pinb);
            rd(8'hc1, 2, {cfg1, 1'b0, seed[14], s2});
        end
        wr(8'h02, 1, {8'h80, 8'h00});
        note({cfg1[7], 2'b11, src[s] ^ cfg1[6], 1'b1, src[0], 2'b00},
            pinb);
        wr(8'h01, 1, {8'h2e, 8'h00});
        note(8'h48 | {5'h0, src[0], 2'b00}, pinb);
        host.sel(1'b1);
        host.xfer(8'h35, r);
        host.xfer(8'h3e, r);
        host.xfer(8'h5a, r);
        host.sel(1'b0);
        note(8'h35, {2'b00, strobe_addr});
        note(8'h01, 8'(n_strobe));
        wr(8'h05, 1, {8'h77, 8'h00});
        rd(8'h85, 1, 16'h0000);
        rd(8'hbe, 1, 16'h0000);
        rd(8'hc1, 2, 16'h2e80);
        host.tick(1);
        arst_n = 1'b0;
        host.tick(3);
        arst_n = 1'b1;
        host.tick(1);
        note(8'h08, pinb & 8'hf8);
        note(8'h00, {2'b00, strobe_addr});
        note(8'h00, {7'h00, so_oe});
        rd(8'hc1, 2, {RST_OUT1_CFG, RST_OUT0_CFG});
        host.tick(2);
        results();
    end
endmodule
